/* File: ctl_pkg.sv */
// Function
// - four-bit line selector in bits 0..3 picks line for later loads
// - bits 4 and 5 supply address bits 16 and 17 of loaded address
// - bits 4 and 5 read back last written value, not line storage
// - bit 6 enables receiver alarm interrupt from bit 7
// - bit 7 set when queue fill exceeds alarm level
// - alarm and overflow flags writable only in maintenance mode
// - writing one to bit 8 clears bit 10; bit 8 self-clears
// - bit 9 set means maintenance mode
// - bit 10 set on bus master transfer timeout; bit 13 gates its interrupt and that of bit 15
// - bit 10 read-only except in maintenance mode
// - bit 11 drives device-wide initialize, clearing queue, lines and registers
// - bit 12 enables overflow interrupt from bit 14
// - bit 13 gates interrupts from bits 10 and 15
// - bit 14 set when scanner finds character but queue full
// - bit 15 set when bus master fetch brings byte count to zero
// - bit 15 set by fetch_done_zero in any cycle except one where bit 11 is set; the set wins over a same-cycle write
// - byte and word writes both accepted
package ctl_pkg;
    localparam logic [11:0] CTL_OFFSET = 12'h000;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam int SEL_LSB = 0;
    localparam int EXT_LSB = 4;
    localparam int RX_IE = 6;
    localparam int RX_ALARM = 7;
    localparam int CLR_NXM = 8;
    localparam int MAINT = 9;
    localparam int NXM = 10;
    localparam int MCLR = 11;
    localparam int OVF_IE = 12;
    localparam int TX_IE = 13;
    localparam int OVF = 14;
    localparam int TX_DONE = 15;
    localparam int CLK_MHZ = 250;
    localparam int NXM_TIMEOUT_US = 20;
    localparam int NXM_CYCLES = NXM_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W = 13;
endpackage : ctl_pkg

/* File: line_select_control.sv */
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
module line_select_control #(
    parameter int NXM_CYC = ctl_pkg::NXM_CYCLES
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // events from the rest of the device
    input wire logic [7:0] queue_count,
    input wire logic [7:0] alarm_level,
    input wire logic queue_full_drop,
    input wire logic xfer_start,
    input wire logic xfer_ack,
    input wire logic fetch_done_zero,
    // outputs to the rest of the device
    output logic [3:0] line_sel,
    output logic [1:0] addr_ext,
    output logic maint_mode,
    output logic init_pulse,
    output logic xfer_timeout,
    output logic rx_irq,
    output logic ovf_irq,
    output logic tx_irq
);
    import ctl_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic [15:0] ctl_q;
    logic [CNT_W-1:0] wait_q;
    logic wait_busy_q;
    logic wr_acc;
    logic hit;
    logic lo_we;
    logic hi_we;
    logic nxm_timeout;
    logic alarm_ev;

    // strobe means byte lane enabled, word write enables both
    function automatic logic lane(input logic [3:0] s, input int i);
        return s[i];
    endfunction : lane

    assign hit = (paddr == CTL_OFFSET);
    assign wr_acc = psel && penable && pwrite && hit;
    assign lo_we = wr_acc && lane(pstrb, 0);
    assign hi_we = wr_acc && lane(pstrb, 1);
    assign alarm_ev = queue_count > alarm_level;
    assign nxm_timeout = wait_busy_q && !xfer_ack && (wait_q == CNT_W'(NXM_CYC - 1));

    ////////////////////////////////////////////////////////////////////
    // zero wait state slave; unmapped addresses error, read zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite && hit) begin
                prdata <= {16'h0000, ctl_q};
            end else begin
                // unmapped reads and idle cycles must not leak stale data
                prdata <= 32'h0000_0000;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus master wait counter; ack or timeout ends the wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_q <= '0;
            wait_busy_q <= 1'b0;
        end else if (ctl_q[MCLR]) begin
            wait_q <= '0;
            wait_busy_q <= 1'b0;
        end else if (xfer_start) begin
            wait_q <= '0;
            wait_busy_q <= 1'b1;
        end else if (xfer_ack || nxm_timeout) begin
            wait_busy_q <= 1'b0;
        end else if (wait_busy_q) begin
            wait_q <= wait_q + CNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control register; hardware sets win over software writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_q <= CTL_RESET;
        end else if (ctl_q[MCLR]) begin
            ctl_q <= CTL_RESET;
        end else begin
            if (lo_we) begin
                ctl_q[3:0] <= pwdata[3:0];
                ctl_q[5:4] <= pwdata[5:4];
                ctl_q[RX_IE] <= pwdata[RX_IE];
                if (ctl_q[MAINT]) begin
                    ctl_q[RX_ALARM] <= pwdata[RX_ALARM];
                end
            end
            if (hi_we) begin
                ctl_q[MAINT] <= pwdata[MAINT];
                ctl_q[MCLR] <= pwdata[MCLR];
                ctl_q[OVF_IE] <= pwdata[OVF_IE];
                ctl_q[TX_IE] <= pwdata[TX_IE];
                ctl_q[TX_DONE] <= pwdata[TX_DONE];
                if (ctl_q[MAINT]) begin
                    ctl_q[NXM] <= pwdata[NXM];
                    ctl_q[OVF] <= pwdata[OVF];
                end
                if (pwdata[CLR_NXM]) begin
                    ctl_q[NXM] <= 1'b0;
                end
            end
            // bit 8 never stores, so it always reads zero
            ctl_q[CLR_NXM] <= 1'b0;
            if (alarm_ev) begin
                ctl_q[RX_ALARM] <= 1'b1;
            end
            if (queue_full_drop) begin
                ctl_q[OVF] <= 1'b1;
            end
            if (nxm_timeout) begin
                ctl_q[NXM] <= 1'b1;
            end
            if (fetch_done_zero) begin
                ctl_q[TX_DONE] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registered outputs toward the device
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_sel <= 4'h0;
            addr_ext <= 2'h0;
            maint_mode <= 1'b0;
            init_pulse <= 1'b0;
            xfer_timeout <= 1'b0;
            rx_irq <= 1'b0;
            ovf_irq <= 1'b0;
            tx_irq <= 1'b0;
        end else begin
            line_sel <= ctl_q[3:0];
            addr_ext <= ctl_q[5:4];
            maint_mode <= ctl_q[MAINT];
            init_pulse <= ctl_q[MCLR];
            xfer_timeout <= nxm_timeout;
            rx_irq <= ctl_q[RX_ALARM] && ctl_q[RX_IE];
            ovf_irq <= ctl_q[OVF] && ctl_q[OVF_IE];
            tx_irq <= (ctl_q[NXM] || ctl_q[TX_DONE]) && ctl_q[TX_IE];
        end
    end
endmodule : line_select_control

/* File: line_select_control_asserts.sv */
`timescale 1ns/10ps
module line_select_control_asserts (
    // apb side
    input wire logic pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic [31:0] prdata,
    // device side
    input wire logic [7:0] queue_count, alarm_level,
    input wire logic [3:0] line_sel,
    input wire logic [1:0] addr_ext,
    input wire logic init_pulse, rx_irq, ovf_irq, tx_irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////
    // a completed read shows the register as the outputs see it
    wire rd = psel && penable && pready && !pwrite && !pslverr;
    chk_sel_out: assert property (rd |-> line_sel == prdata[3:0]) else $error("sel");
    chk_ext_out: assert property (rd |-> addr_ext == prdata[5:4]) else $error("ext");
    chk_alarm_set: assert property (rd && $past(queue_count > alarm_level, 2) |-> prdata[7])
        else $error("alarm");
    chk_rx_req: assert property (rd |-> rx_irq == (prdata[6] && prdata[7])) else $error("rx");
    chk_ovf_req: assert property (rd |-> ovf_irq == (prdata[12] && prdata[14]))
        else $error("ovf");
    chk_tx_req: assert property (rd |-> tx_irq == (prdata[13] && (prdata[10] || prdata[15])))
        else $error("tx");
    chk_clr_bit: assert property (rd |-> !prdata[8]) else $error("bit8");
    chk_init_one: assert property (init_pulse |=> !init_pulse) else $error("init");
    cover property (rd && prdata[7]);
    cover property (tx_irq && ovf_irq);
    cover property (init_pulse);
endmodule : line_select_control_asserts

/* File: bus_slave_model.sv */
`timescale 1ns/10ps
module bus_slave_model (
    // clock and reset
    input wire logic pclk, presetn,
    // transfer start, answer delay, answer
    input wire logic xfer_start,
    input wire logic [7:0] ack_delay,
    output logic xfer_ack
);
    int left_q;
    // answer after ack_delay cycles; a long delay stands for no slave at all
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 0;
            xfer_ack <= 1'b0;
        end else begin
            xfer_ack <= (left_q == 1);
            left_q <= xfer_start ? int'(ack_delay) : (left_q > 0 ? left_q - 1 : 0);
        end
    end
endmodule : bus_slave_model

/* File: line_select_control_bench.sv */
`timescale 1ns/10ps
module line_select_control_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic queue_full_drop = 0, xfer_start = 0, xfer_ack, fetch_done_zero = 0, err;
    logic maint_mode, init_pulse, xfer_timeout, rx_irq, ovf_irq, tx_irq;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [11:0] paddr = '0;
    logic [7:0] queue_count = '0, alarm_level = '0, ack_delay = '0;
    logic [3:0] pstrb = '0, line_sel;
    logic [1:0] addr_ext;
    int mismatches = 0, total_checks = 0, cyc = 0, to_cnt = 0;
    // short timeout count keeps the run brief
    line_select_control #(.NXM_CYC(20)) line_select_control_i (.*);
    bus_slave_model bus_slave_model_i (.*);
    initial forever #2 pclk = ~pclk;
    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (xfer_timeout === 1'b1) to_cnt++;
        if (cyc == 3000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic rdc(input string n, input logic [15:0] e);
        apb(1'b0, 12'h000, '0, '0);
        chk(n, {16'h0000, e}, rd);
    endtask : rdc
    task automatic wr(input logic [15:0] d, input logic [3:0] s = 4'h3);
        apb(1'b1, 12'h000, {16'h0000, d}, s);
    endtask : wr
    task automatic s_xfer(input logic [7:0] dly, input logic [15:0] e, input int nto);
        ack_delay <= dly;
        xfer_start <= 1'b1;
        @(posedge pclk);
        xfer_start <= 1'b0;
        repeat (30) @(posedge pclk);
        rdc("nxm", e);
        chk("xfer_timeout", 32'(nto), 32'(to_cnt));
    endtask : s_xfer
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        wr(16'hF5FF);
        rdc("plain", 16'hB07F);
        chk("sel_ext", 32'h3F, {addr_ext, line_sel});
        wr(16'h0000, 4'h2);
        rdc("upper", 16'h007F);
        apb(1'b1, 12'h004, '0, 4'h3);
        chk("slverr", 32'h1, 32'(err));
        rdc("unmapped", 16'h007F);
        wr(16'h0000);
        wr(16'h4680);
        rdc("no_maint", 16'h0200);
        wr(16'h4680);
        rdc("maint", 16'h4680);
        chk("maint_mode", 32'h1, 32'(maint_mode));
        wr(16'h0400);
        rdc("kept", 16'h0400);
        wr(16'h0100);
        rdc("nxm_clr", 16'h0000);
        wr(16'h0800);
        rdc("init", 16'h0000);
        wr(16'h3040);
        queue_count <= 8'h04;
        alarm_level <= 8'h04;
        rdc("at_level", 16'h3040);
        queue_count <= 8'h05;
        @(posedge pclk);
        rdc("over", 16'h30C0);
        queue_full_drop <= 1'b1;
        fetch_done_zero <= 1'b1;
        @(posedge pclk);
        queue_full_drop <= 1'b0;
        fetch_done_zero <= 1'b0;
        rdc("ovf_tx", 16'hF0C0);
        chk("irqs", 32'h7, {rx_irq, ovf_irq, tx_irq});
        s_xfer(8'h03, 16'hF0C0, 0);
        s_xfer(8'hFF, 16'hF4C0, 1);
        finish_test();
    end
endmodule : line_select_control_bench
bind line_select_control line_select_control_asserts line_select_control_asserts_i (.*);
